// *** hw/epu_defs.svh ***
// opcodes, field widths, reset values and counts for the update/ram/status command decoder
`ifndef EPU_DEFS_SVH
`define EPU_DEFS_SVH
`define EPU_OP_HV_DET   8'h14
`define EPU_OP_VCI_DET  8'h15
`define EPU_OP_TEMP     8'h1A
`define EPU_OP_ACTIVATE 8'h20
`define EPU_OP_RAM_OPT  8'h21
`define EPU_OP_STAGES   8'h22
`define EPU_OP_WR_MONO  8'h24
`define EPU_OP_WR_RED   8'h26
`define EPU_OP_OTP_RD   8'h2D
`define EPU_OP_STATUS   8'h2F
`define EPU_TEMP_HI_RST 8'h7F
`define EPU_TEMP_LO_RST 4'hF
`define EPU_RAM_OPT_RST 4'h0
`define EPU_STAGES_RST  8'hC7
`define EPU_OTP_LAST    3'h7
`define EPU_STAT_LAST   3'h0
`define EPU_BIT_LAST    3'h7
`define EPU_X_W         5
`define EPU_Y_W         9
`define EPU_X_LAST_DEF  5'h0F
`define EPU_Y_LAST_DEF  9'h127
`endif

// *** hw/epu_pkg.sv ***
// types shared by the update/ram/status command decoder
`include "epu_defs.svh"
package epu_pkg;
	typedef enum logic [2:0] {
		EPU_IDLE,
		EPU_TEMP_HI,
		EPU_TEMP_LO,
		EPU_RAM_OPT,
		EPU_STAGES,
		EPU_WR_RAM,
		EPU_READ,
		EPU_IGNORE
	} epu_state_t;

	// one pixel byte bound for the image planes
	typedef struct packed {
		logic                 red_plane;
		logic [`EPU_X_W-1:0]  x;
		logic [`EPU_Y_W-1:0]  y;
		logic [7:0]           data;
	} epu_ram_wr_t;
endpackage

// *** hw/epu_cmd.sv ***
// command decoder for temperature, update control, image ram writes, otp and status reads
`timescale 1ns/1ns
`default_nettype none
`include "epu_defs.svh"

// two-flop synchroniser for pin inputs
module epu_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

// pixel byte fifo between the link and the image ram port
module epu_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	wire          push = in_valid_i & in_ready_o;
	wire          pop  = out_valid_o & out_ready_i;
	assign out_valid_o = wr_q != rd_q;
	assign in_ready_o  = (wr_q[AW-1:0] != rd_q[AW-1:0]) | (wr_q[AW] == rd_q[AW]);
	assign out_data_o  = mem_q[rd_q[AW-1:0]];
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end
endmodule

// Summary of operation
// - 1A loads twelve bit temperature, msb first
// - 20 starts update with chosen stages
// - 21 low nibble picks mono ram usage
// - 22 stores stage byte, C7 full sequence
// - stage code with bit 6 clear loads table from otp
// - after 24 bytes go to mono plane
// - after 26 bytes go to red plane
// - writes run to next opcode, address steps
// - 2D returns eight otp bytes
// - status bit 5 high voltage not ready
// - status bit 4 supply below detect level
// - status bit 2 busy, bit 3 zero
// - status bits 1:0 chip id, 7:6 zero
// - detect bits valid only after 14/15
module epu_cmd
	import epu_pkg::*;
#(
	parameter logic [`EPU_X_W-1:0] X_LAST     = `EPU_X_LAST_DEF,
	parameter logic [`EPU_Y_W-1:0] Y_LAST     = `EPU_Y_LAST_DEF,
	parameter int                  FIFO_DEPTH = 16,
	parameter logic [1:0]          CHIP_ID    = 2'h2 // arbitrary value
) (
	input  wire logic                ref_clk_i,
	input  wire logic                reset_n_i,
	input  wire logic                link_sclk_i,
	input  wire logic                link_cs_n_i,
	input  wire logic                link_dc_i,
	input  wire logic                link_sdio_i,
	output logic                     link_sdio_o,
	output logic                     link_sdio_oe_o,
	output logic                     busy_o,
	input  wire logic                hv_not_ready_i,
	input  wire logic                supply_low_i,
	input  wire logic [0:7][7:0]     otp_bytes_i,
	input  wire logic [1:0]          addr_inc_i,
	input  wire logic                addr_y_first_i,
	input  wire logic                ram_addr_load_i,
	input  wire logic [`EPU_X_W-1:0] ram_x_init_i,
	input  wire logic [`EPU_Y_W-1:0] ram_y_init_i,
	output logic                     ram_wr_valid_o,
	input  wire logic                ram_wr_ready_i,
	output epu_ram_wr_t              ram_wr_o,
	input  wire logic                update_done_i,
	output logic                     update_start_o,
	output logic [7:0]               update_stages_o,
	output logic                     stages_from_otp_o,
	output logic [3:0]               mono_ram_option_o,
	output logic [11:0]              temperature_value_o
);
	logic        s_sclk, s_cs_n, s_dc, s_sdio, s_hv, s_vci;
	logic        sclk_d_q;
	logic [2:0]  bit_q;
	logic [6:0]  rx_q;
	logic [7:0]  tx_q;
	logic [2:0]  rd_idx_q;
	logic [2:0]  rd_last_q;
	logic        red_q;
	logic [`EPU_X_W-1:0] x_q;
	logic [`EPU_Y_W-1:0] y_q;
	logic        hv_flag_q, vci_flag_q, upd_busy_q;
	epu_state_t  state_q, state_d;
	epu_ram_wr_t push_word;
	logic        fifo_in_ready;

	epu_sync #(.W(6)) u_sync (
		.clk_i     (ref_clk_i),
		.reset_n_i (reset_n_i),
		.d_i       ({link_sclk_i, link_cs_n_i, link_dc_i, link_sdio_i, hv_not_ready_i, supply_low_i}),
		.q_o       ({s_sclk, s_cs_n, s_dc, s_sdio, s_hv, s_vci})
	);

	// link clock is only sampled; edges found against the synced copy
	wire       sclk_rise = s_sclk & ~sclk_d_q & ~s_cs_n;
	wire       sclk_fall = ~s_sclk & sclk_d_q & ~s_cs_n;
	wire       byte_done = sclk_rise & (bit_q == `EPU_BIT_LAST);
	wire [7:0] rx_byte   = {rx_q, s_sdio};
	wire       got_cmd   = byte_done & ~s_dc;
	wire       got_par   = byte_done & s_dc;
	wire       op_temp   = got_cmd & (rx_byte == `EPU_OP_TEMP);
	wire       op_act    = got_cmd & (rx_byte == `EPU_OP_ACTIVATE);
	wire       op_opt    = got_cmd & (rx_byte == `EPU_OP_RAM_OPT);
	wire       op_stage  = got_cmd & (rx_byte == `EPU_OP_STAGES);
	wire       op_mono   = got_cmd & (rx_byte == `EPU_OP_WR_MONO);
	wire       op_red    = got_cmd & (rx_byte == `EPU_OP_WR_RED);
	wire       op_otp    = got_cmd & (rx_byte == `EPU_OP_OTP_RD);
	wire       op_stat   = got_cmd & (rx_byte == `EPU_OP_STATUS);
	wire       op_hv     = got_cmd & (rx_byte == `EPU_OP_HV_DET);
	wire       op_vci    = got_cmd & (rx_byte == `EPU_OP_VCI_DET);
	// a full fifo shows as busy so the host holds off
	wire       busy      = upd_busy_q | ~fifo_in_ready;
	wire [7:0] status    = {2'b00, hv_flag_q, vci_flag_q, 1'b0, busy, CHIP_ID};
	wire       rd_more   = rd_idx_q != rd_last_q;
	wire       in_read   = state_q == EPU_READ;
	wire       wr_par    = got_par & (state_q == EPU_WR_RAM);
	wire       push      = wr_par & fifo_in_ready;

	function automatic logic [8:0] step_f(input logic [8:0] v, input logic [8:0] last, input logic inc);
		if (inc) begin
			step_f = (v == last) ? 9'h000 : 9'(v + 9'h001);
		end else begin
			step_f = (v == 9'h000) ? last : 9'(v - 9'h001);
		end
	endfunction

	wire [8:0]          x_step = step_f(9'(x_q), 9'(X_LAST), addr_inc_i[0]);
	wire [`EPU_X_W-1:0] x_nxt  = x_step[`EPU_X_W-1:0];
	wire [`EPU_Y_W-1:0] y_nxt  = step_f(y_q, Y_LAST, addr_inc_i[1]);
	wire                x_wrap = addr_inc_i[0] ? (x_q == X_LAST) : (x_q == '0);
	wire                y_wrap = addr_inc_i[1] ? (y_q == Y_LAST) : (y_q == '0);

	assign push_word.red_plane = red_q;
	assign push_word.x         = x_q;
	assign push_word.y         = y_q;
	assign push_word.data      = rx_byte;
	assign link_sdio_o         = tx_q[7];
	assign link_sdio_oe_o      = in_read & ~s_cs_n;
	assign busy_o              = busy;
	assign stages_from_otp_o   = ~update_stages_o[6];

	// any opcode ends the previous command's parameter phase
	always_comb begin
		state_d = state_q;
		if (got_cmd) begin
			state_d = EPU_IGNORE;
			if (op_temp) begin
				state_d = EPU_TEMP_HI;
			end else if (op_opt) begin
				state_d = EPU_RAM_OPT;
			end else if (op_stage) begin
				state_d = EPU_STAGES;
			end else if (op_mono | op_red) begin
				state_d = EPU_WR_RAM;
			end else if (op_otp | op_stat) begin
				state_d = EPU_READ;
			end
		end else if (got_par) begin
			case (state_q)
				EPU_TEMP_HI: state_d = EPU_TEMP_LO;
				EPU_TEMP_LO: state_d = EPU_IGNORE;
				EPU_RAM_OPT: state_d = EPU_IGNORE;
				EPU_STAGES:  state_d = EPU_IGNORE;
				EPU_READ:    state_d = rd_more ? EPU_READ : EPU_IDLE;
				default:     state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_d_q <= 1'b0;
			bit_q    <= 3'h0;
			rx_q     <= 7'h00;
			state_q  <= EPU_IDLE;
		end else begin
			sclk_d_q <= s_sclk;
			rx_q     <= sclk_rise ? rx_byte[6:0] : rx_q;
			bit_q    <= s_cs_n ? 3'h0 : bit_q + 3'(sclk_rise);
			state_q  <= state_d;
		end
	end

	// read bytes: msb out first, next bit after each falling edge inside a byte
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_q      <= 8'h00;
			rd_idx_q  <= 3'h0;
			rd_last_q <= 3'h0;
		end else if (op_stat) begin
			tx_q      <= status;
			rd_idx_q  <= 3'h0;
			rd_last_q <= `EPU_STAT_LAST;
		end else if (op_otp) begin
			tx_q      <= otp_bytes_i[0];
			rd_idx_q  <= 3'h0;
			rd_last_q <= `EPU_OTP_LAST;
		end else if (in_read & got_par & rd_more) begin
			tx_q     <= otp_bytes_i[3'(rd_idx_q + 3'h1)];
			rd_idx_q <= rd_idx_q + 3'h1;
		end else if (in_read & sclk_fall & (bit_q != 3'h0)) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			temperature_value_o <= {`EPU_TEMP_HI_RST, `EPU_TEMP_LO_RST};
			mono_ram_option_o   <= `EPU_RAM_OPT_RST;
			update_stages_o     <= `EPU_STAGES_RST;
		end else if (got_par) begin
			if (state_q == EPU_TEMP_HI) begin
				temperature_value_o[11:4] <= rx_byte;
			end
			if (state_q == EPU_TEMP_LO) begin
				temperature_value_o[3:0] <= rx_byte[7:4];
			end
			if (state_q == EPU_RAM_OPT) begin
				mono_ram_option_o <= rx_byte[3:0];
			end
			if (state_q == EPU_STAGES) begin
				update_stages_o <= rx_byte;
			end
		end
	end

	// start wins over done; stages themselves run outside this block
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			update_start_o <= 1'b0;
			upd_busy_q     <= 1'b0;
		end else begin
			update_start_o <= op_act;
			upd_busy_q     <= op_act | (upd_busy_q & ~update_done_i);
		end
	end

	// detect flags keep power-on values until their detect opcode
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hv_flag_q  <= 1'b1;
			vci_flag_q <= 1'b0;
		end else begin
			hv_flag_q  <= op_hv ? s_hv : hv_flag_q;
			vci_flag_q <= op_vci ? s_vci : vci_flag_q;
		end
	end

	// address steps only on accepted bytes; a byte seen while full is dropped
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			red_q <= 1'b0;
			x_q   <= '0;
			y_q   <= '0;
		end else begin
			red_q <= op_red ? 1'b1 : (op_mono ? 1'b0 : red_q);
			if (ram_addr_load_i) begin
				x_q <= ram_x_init_i;
				y_q <= ram_y_init_i;
			end else if (push & ~addr_y_first_i) begin
				x_q <= x_nxt;
				y_q <= x_wrap ? y_nxt : y_q;
			end else if (push) begin
				y_q <= y_nxt;
				x_q <= y_wrap ? x_nxt : x_q;
			end
		end
	end

	epu_fifo #(.W($bits(epu_ram_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i       (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (wr_par),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_word),
		.out_valid_o (ram_wr_valid_o),
		.out_ready_i (ram_wr_ready_i),
		.out_data_o  (ram_wr_o)
	);
endmodule
`default_nettype wire

// *** testbench/epu_cmd_props.sv ***
// port assertions for the command decoder
`timescale 1ns/1ns
`default_nettype none
module epu_cmd_props
	import epu_pkg::*;
(
	input wire logic	ref_clk_i,
	input wire logic	reset_n_i,
	input wire logic	link_cs_n_i,
	input wire logic	link_sdio_oe_o,
	input wire logic	busy_o,
	input wire logic	update_done_i,
	input wire logic	update_start_o,
	input wire logic [7:0]	update_stages_o,
	input wire logic	stages_from_otp_o,
	input wire logic [3:0]	mono_ram_option_o,
	input wire logic [11:0]	temperature_value_o,
	input wire logic	ram_wr_valid_o,
	input wire logic	ram_wr_ready_i,
	input wire epu_ram_wr_t	ram_wr_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	start_pulse_a: assert property (update_start_o |=> !update_start_o) else $error("start too long");
	start_busy_a: assert property (update_start_o |-> ##[0:2] busy_o) else $error("no busy");
	otp_flag_a: assert property (stages_from_otp_o == !update_stages_o[6]) else $error("stage source");
	oe_cs_a: assert property (link_cs_n_i [*4] |-> !link_sdio_oe_o) else $error("drives deselected");
	cfg_hold_a: assert property (link_cs_n_i [*6] |-> $stable({temperature_value_o, update_stages_o,
		mono_ram_option_o})) else $error("settings moved");
	start_cs_a: assert property (link_cs_n_i [*6] |-> !update_start_o) else $error("stray start");
	ram_hold_a: assert property (ram_wr_valid_o && !ram_wr_ready_i |=> ram_wr_valid_o && $stable(ram_wr_o))
		else $error("head lost");
	busy_clear_a: assert property (link_cs_n_i [*6] ##0 (update_done_i && !ram_wr_valid_o) |=> !busy_o)
		else $error("busy stuck");
endmodule
bind epu_cmd epu_cmd_props u_props (.ref_clk_i, .reset_n_i, .link_cs_n_i, .link_sdio_oe_o, .busy_o, .update_done_i,
	.update_start_o, .update_stages_o, .stages_from_otp_o, .mono_ram_option_o, .temperature_value_o,
	.ram_wr_valid_o, .ram_wr_ready_i, .ram_wr_o);
`default_nettype wire

// *** testbench/epu_host.sv ***
// host model: link frames and bytes
`timescale 1ns/1ns
`default_nettype none
module epu_host (
	output logic		sclk_o,
	output logic		cs_n_o,
	output logic		dc_o,
	output logic		sdio_o,
	input wire logic	dev_sdio_i,
	input wire logic	dev_oe_i
);
	logic drv;
	assign sdio_o = dev_oe_i ? dev_sdio_i : drv;
	initial {sclk_o, cs_n_o, dc_o, drv} = 4'h4;
	// clock stands low between frames
	task frame(input logic on);
		sclk_o = 1'b0;
		#400;
		cs_n_o = !on;
		#400;
	endtask
	// released line toggles so a stale level never passes for read data
	task xfer(input logic c, input logic rd, input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_o = 1'b0;
			dc_o = c;
			drv = rd ? ~drv : tx[i];
			#400;
			sclk_o = 1'b1;
			rx[i] = sdio_o;
			#400;
		end
	endtask
endmodule
`default_nettype wire

// *** testbench/test_epu_cmd.sv ***
// self-checking bench for the command decoder
`timescale 1ns/1ns
`default_nettype none
module test_epu_cmd;
	import epu_pkg::*;
	localparam logic [1:0] ID = 2'h3; // arbitrary value
	localparam logic [4:0] XL = 5'h03;
	localparam logic [8:0] YL = 9'h127;
	logic clk, rst_n, link_sclk_i, link_cs_n_i, link_dc_i, link_sdio_i, link_sdio_o, link_sdio_oe_o, busy;
	logic hv, sup, ld, valid, ready, update_done_i, update_start_o, fotp, drain;
	logic [0:7][7:0] otp;
	logic [4:0] xi, x, xn;
	logic [8:0] yi, y, yn;
	logic [1:0] inc;
	logic yf, xw, yw, eh, ev;
	logic [7:0] stg, d, a, b;
	logic [3:0] opt;
	logic [11:0] temp;
	epu_ram_wr_t wr;
	epu_ram_wr_t q[$];
	int err_count, n_compared, starts;
	epu_host h (.sclk_o(link_sclk_i), .cs_n_o(link_cs_n_i), .dc_o(link_dc_i), .sdio_o(link_sdio_i),
		.dev_sdio_i(link_sdio_o), .dev_oe_i(link_sdio_oe_o));
	epu_cmd #(.X_LAST(XL), .Y_LAST(YL), .CHIP_ID(ID)) DUT (.ref_clk_i(clk), .reset_n_i(rst_n), .link_sclk_i,
		.link_cs_n_i, .link_dc_i, .link_sdio_i, .link_sdio_o, .link_sdio_oe_o, .busy_o(busy), .hv_not_ready_i(hv),
		.supply_low_i(sup), .otp_bytes_i(otp), .addr_inc_i(inc), .addr_y_first_i(yf), .ram_addr_load_i(ld),
		.ram_x_init_i(xi), .ram_y_init_i(yi), .ram_wr_valid_o(valid), .ram_wr_ready_i(ready), .ram_wr_o(wr),
		.update_done_i, .update_start_o, .update_stages_o(stg), .stages_from_otp_o(fotp),
		.mono_ram_option_o(opt), .temperature_value_o(temp));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask
	task close_out;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task op(input logic [7:0] o); h.xfer(1'b0, 1'b0, o, d); endtask
	task par(input logic [7:0] p); h.xfer(1'b1, 1'b0, p, d); endtask
	task rdb; h.xfer(1'b1, 1'b1, 8'h00, d); endtask
	task tick; @(posedge clk); #5; endtask
	task drainq; for (int i = 0; i < 300 && valid !== 1'b0; i++) tick; endtask
	// address step as the direction pins ask, wrapping at both ends
	function automatic logic [8:0] nxt(input logic [8:0] v, input logic [8:0] l, input logic up);
		if (up) return (v == l) ? 9'h000 : 9'(v + 9'h001);
		return (v == 9'h000) ? l : 9'(v - 9'h001);
	endfunction
	task load;
		tick;
		{xi, yi, ld, inc, yf} = {5'($urandom_range(3)), 9'($urandom_range(200)), 1'b1, 3'($urandom)};
		{x, y} = {xi, yi};
		tick;
		ld = 1'b0;
	endtask
	task wrb(input logic pl);
		a = 8'($urandom);
		q.push_back('{pl, x, y, a});
		xn = 5'(nxt(9'(x), 9'(XL), inc[0]));
		yn = nxt(y, YL, inc[1]);
		xw = x == (inc[0] ? XL : 5'h00);
		yw = y == (inc[1] ? YL : 9'h000);
		{x, y} = yf ? {yw ? xn : x, yn} : {xn, xw ? yn : y};
		par(a);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#2_000_000;
		err_count++;
		close_out;
	end
	always @(posedge clk) begin
		#5;
		ready = drain && $urandom_range(1);
	end
	always @(posedge clk) if (valid === 1'b1 && ready === 1'b1) chk(32'(wr), q.size() ? 32'(q.pop_front()) : '1);
	always @(posedge clk) if (update_start_o === 1'b1) starts++;
	initial begin
		void'($urandom(32'h3965FBEA));
		{rst_n, hv, sup, ld, update_done_i, drain, xi, yi, inc, yf} = {6'h10, 17'h00000};
		otp = {$urandom, $urandom};
		repeat (10) @(posedge clk);
		#5;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#5;
		chk(32'({temp, stg, opt, busy}), 32'({12'h7FF, 8'hC7, 4'h0, 1'b0}));
		{eh, ev} = 2'b10;
		for (int i = 0; i < 3; i++) begin
			h.frame(1'b1);
			op(8'h2F);
			rdb;
			h.frame(1'b0);
			chk(32'(d), 32'({2'b00, eh, ev, 2'b00, ID}));
			{hv, sup} = 2'($urandom);
			{eh, ev} = {hv, sup};
			h.frame(1'b1);
			op(8'h14);
			op(8'h15);
			h.frame(1'b0);
		end
		{a, b} = 16'($urandom);
		h.frame(1'b1);
		op(8'h1A);
		par(a);
		par(b);
		par(~a);
		op(8'h21);
		par(b);
		h.frame(1'b0);
		chk(32'({temp, opt}), 32'({a, b[7:4], b[3:0]}));
		for (int i = 0; i < 2; i++) begin
			b = i ? 8'hC7 : 8'h90;
			h.frame(1'b1);
			op(8'h22);
			par(b);
			h.frame(1'b0);
			chk(32'({stg, fotp}), 32'({b, ~b[6]}));
		end
		h.frame(1'b1);
		op(8'h20);
		h.frame(1'b0);
		chk(32'(busy), 32'h1);
		chk(32'(starts), 32'h1);
		tick;
		update_done_i = 1'b1;
		tick;
		update_done_i = 1'b0;
		chk(32'(busy), 32'h0); // host holds off until here
		load;
		h.frame(1'b1);
		op(8'h24);
		repeat (16) wrb(1'b0);
		chk(32'(busy), 32'h1);
		par(8'h5A);
		drain = 1'b1;
		drainq;
		load;
		op(8'h26);
		repeat (6) wrb(1'b1);
		op(8'h2D);
		for (int i = 0; i < 8; i++) begin
			rdb;
			chk(32'(d), 32'(otp[i]));
		end
		h.frame(1'b0);
		drainq;
		chk(32'({q.size(), link_sdio_oe_o}), 32'h0);
		close_out;
	end
endmodule
`default_nettype wire
